// *** tb/embc_mem_model.sv ***
// embc_mem_model: far-side memory and card socket for embc_ctrl.
// assumes: selects low active, wait held for wait_len cycles per access.
`timescale 1ns/1ps
module embc_mem_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [5:0] sel_n,
  input  wire logic [3:0] wait_len,
  input  wire logic       endian_strap,
  input  wire logic       io16_req,
  output logic            ext_wait_n,
  output logic            card_io_16bit_n
);
  // ---------------------------------------------------------------
  // wait generator
  // ---------------------------------------------------------------
  logic [3:0] cnt_reg, cnt_next;
  logic       act_reg, act_next;
  always_comb begin
    act_next = ~(&sel_n);
    cnt_next = cnt_reg;
    if (act_next && !act_reg) begin
      cnt_next = wait_len;
    end else if (cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_reg <= 4'h0;
      act_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
    end
  end
  assign ext_wait_n = (cnt_reg == 4'h0);
  // big endian system keeps the 16-bit indication low
  assign card_io_16bit_n = endian_strap ? ~io16_req : 1'b0;
endmodule : embc_mem_model

// *** tb/tb_top.sv ***
// tb_top: self-checking bench for embc_ctrl with a far-side model.
// assumes: embc_pkg compiled first; every area is normal space except area 0 in the burst ROM test.
`timescale 1ns/1ps
module tb_top;
  import embc_pkg::*;
  typedef struct packed {
    logic map; logic [2:0] code; logic half; logic wr;
    logic [3:0] lanes; logic [5:0] sel; logic dn;
  } embc_row_s;
  logic ref_clk, reset, clk_en, req_valid, req_ready, req_write, done_pulse;
  logic [28:0] req_addr, ext_addr;
  logic [3:0]  req_lanes, req_beats, wait_len, seen_we;
  logic [3:0]  idle_rw_same, idle_rw_diff, idle_rr_same, idle_rr_diff;
  logic [3:0]  idle_first_wr;
  logic map_select, endian_strap, area0_width_strap, ext_wait_n, io16_req;
  logic card_io_16bit_n, little_endian, card_io_16, rw_direction;
  logic [1:0]  area0_width, cur_width;
  logic [15:0] area_if_type, area_width;
  logic [31:0] area_rd_wait, area_wr_wait;
  logic area0_select_n, area4_select_n, area5a_select_n, area5b_select_n;
  logic area6a_select_n, area6b_select_n, bus_cycle_start_n, read_strobe_n;
  logic byte_lane3_write_n, byte_lane2_write_n, byte_lane1_write_n;
  logic byte_lane0_write_n, seen_rd, seen_bs, got_done;
  logic [5:0]  sel_n, seen_sel;
  int lat, base, miscompares, n_compared;
  embc_row_s rows [10];
  assign sel_n = {area0_select_n, area4_select_n, area5a_select_n,
                  area5b_select_n, area6a_select_n, area6b_select_n};
  embc_ctrl i_dut (.ref_clk, .reset, .clk_en, .req_valid, .req_ready,
    .req_write, .req_addr, .req_lanes, .req_beats, .done_pulse, .map_select,
    .area_if_type, .area_width, .area_rd_wait, .area_wr_wait, .idle_rw_same,
    .idle_rw_diff, .idle_rr_same, .idle_rr_diff, .idle_first_wr,
    .endian_strap, .area0_width_strap, .ext_wait_n, .card_io_16bit_n,
    .little_endian, .area0_width, .card_io_16, .cur_width, .ext_addr,
    .area0_select_n, .area4_select_n, .area5a_select_n, .area5b_select_n,
    .area6a_select_n, .area6b_select_n, .bus_cycle_start_n, .rw_direction,
    .read_strobe_n, .byte_lane3_write_n, .byte_lane2_write_n,
    .byte_lane1_write_n, .byte_lane0_write_n);
  embc_mem_model i_mem (.ref_clk, .reset, .sel_n, .wait_len, .endian_strap,
    .io16_req, .ext_wait_n, .card_io_16bit_n);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // straps stay put through the capture window after release
  task automatic do_reset(input logic e, input logic w);
    reset = 1'b1;
    endian_strap = e;
    area0_width_strap = w;
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask : do_reset
  task automatic access(input logic [28:0] a, input logic w,
                        input logic [3:0] ln);
    int i;
    seen_sel = 6'h0; seen_we = 4'h0; seen_rd = 1'b0; seen_bs = 1'b0;
    got_done = 1'b0; lat = 0;
    for (i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge ref_clk);
    if (req_ready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    req_addr = a; req_write = w; req_lanes = ln; req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    for (i = 1; i < 40 && !got_done; i++) begin
      seen_sel |= ~sel_n;
      seen_we |= ~{byte_lane3_write_n, byte_lane2_write_n,
                   byte_lane1_write_n, byte_lane0_write_n};
      seen_rd |= ~read_strobe_n;
      seen_bs |= ~bus_cycle_start_n;
      if (done_pulse === 1'b1) begin
        got_done = 1'b1;
        lat = i;
      end else @(negedge ref_clk);
    end
  endtask : access
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    miscompares = 0; n_compared = 0; reset = 1'b1; clk_en = 1'b1;
    req_valid = 1'b0; req_write = 1'b0; req_addr = 29'h0; req_lanes = 4'h0;
    req_beats = 4'h0; map_select = 1'b0; wait_len = 4'h0; io16_req = 1'b1;
    area_if_type = 16'h0; area_width = 16'hFFFF;
    area_rd_wait = 32'h0; area_wr_wait = 32'h0;
    idle_rw_same = 4'h0; idle_rw_diff = 4'h0; idle_rr_same = 4'h0;
    idle_rr_diff = 4'h0; idle_first_wr = 4'h0;
    endian_strap = 1'b1; area0_width_strap = 1'b1;
    rows = '{'{1'h0, 3'h0, 1'h0, 1'h0, 4'h0, 6'h20, 1'h1},
             '{1'h0, 3'h4, 1'h0, 1'h1, 4'hA, 6'h10, 1'h1},
             '{1'h0, 3'h5, 1'h0, 1'h1, 4'hF, 6'h08, 1'h1},
             '{1'h0, 3'h5, 1'h1, 1'h0, 4'h0, 6'h04, 1'h1},
             '{1'h0, 3'h6, 1'h0, 1'h1, 4'h5, 6'h02, 1'h1},
             '{1'h0, 3'h6, 1'h1, 1'h0, 4'h0, 6'h01, 1'h1},
             '{1'h1, 3'h5, 1'h0, 1'h0, 4'h0, 6'h04, 1'h1},
             '{1'h1, 3'h6, 1'h0, 1'h1, 4'h3, 6'h01, 1'h1},
             '{1'h0, 3'h1, 1'h0, 1'h0, 4'h0, 6'h00, 1'h0},
             '{1'h1, 3'h0, 1'h0, 1'h1, 4'h1, 6'h20, 1'h1}};
    do_reset(1'b1, 1'b1);
    check(8'(sel_n), 8'h3F);
    check(8'(little_endian), 8'h1);
    check(8'(area0_width), 8'(EMBC_WIDTH_32));
    check(8'(card_io_16), 8'h1);
    foreach (rows[k]) begin
      map_select = rows[k].map;
      access({rows[k].code, rows[k].half, 25'h0000100}, rows[k].wr,
             rows[k].lanes);
      check(8'(seen_sel), 8'(rows[k].sel));
      check(8'(seen_bs), 8'(rows[k].dn));
      check(8'(seen_rd), 8'(rows[k].dn & ~rows[k].wr));
      check(8'(seen_we), 8'(rows[k].wr ? rows[k].lanes : 4'h0));
      check(8'(got_done), 8'(rows[k].dn));
      if (got_done !== rows[k].dn) finish_test();
      if (k == 0) base = lat;
    end
    // read wait on area 0 only; write wait must not touch reads
    map_select = 1'b0;
    area_rd_wait = 32'h2;
    area_wr_wait = 32'h3;
    access(29'h0000040, 1'b0, 4'h0);
    check(8'(lat), 8'(base + 2));
    area_rd_wait = 32'h0;
    access(29'h0000040, 1'b0, 4'h0);
    check(8'(lat), 8'(base));
    area_wr_wait = 32'h0;
    // read after read in one area: same-area idle count
    idle_rr_same = 4'h3;
    access(29'h0000040, 1'b0, 4'h0);
    check(8'(lat), 8'(base + 3));
    idle_rr_same = 4'h0;
    // burst ROM: two extra page reads, one wait and one hold each
    area_if_type = 16'h2;
    req_beats = 4'h2;
    access(29'h0000040, 1'b0, 4'h0);
    check(8'(lat), 8'(base + 4));
    check(8'(ext_addr), 8'h48);
    check(8'(seen_bs), 8'h1);
    area_if_type = 16'h0;
    req_beats = 4'h0;
    // wait pin crosses a synchroniser: programmed waits must cover it
    area_rd_wait = 32'h4;
    wait_len = 4'hC;
    access(29'h0000040, 1'b0, 4'h0);
    check(8'(lat > base + 4), 8'h1);
    area_rd_wait = 32'h0;
    wait_len = 4'h0;
    do_reset(1'b0, 1'b0);
    check(8'(little_endian), 8'h0);
    check(8'(area0_width), 8'(EMBC_WIDTH_16));
    check(8'(card_io_16), 8'h0);
    finish_test();
  end
endmodule : tb_top

// *** verilog/embc_ctrl.sv ***
// embc_ctrl: external asynchronous memory bus controller.
// assumes: one internal request port, configuration as plain ports,
// wait/strap/card pins asynchronous to ref_clk.
//
// Contract
// RULE_01 - up to 256 Mbytes, six areas on map 1, four on map 2
// RULE_02 - per area interface: normal, byte-select SRAM, burst ROM, card
// RULE_03 - per area data width of 8, 16 or 32 bits
// RULE_04 - per area wait counts, separate for reads and writes
// RULE_05 - idle cycles for five cases of back-to-back accesses
// RULE_06 - burst ROM reads use successive page accesses
// RULE_07 - card bus sizing only in little endian
// RULE_08 - bus cycle start on normal, burst ROM and card cycles
// RULE_09 - area 5A and 6A selects active only under map 1
// RULE_10 - card mode: A selects upper byte, B selects lower byte; code asserts only the addressed area's select, as in other modes
// RULE_11 - read strobe is data output enable and card memory read
// RULE_12 - four byte write strobes, byte selects for byte-select SRAM
// RULE_13 - card mode: lanes 3,2,1 become io write, io read, mem write
// RULE_14 - card 16-bit input used only in little endian
// RULE_15 - big endian system holds card 16-bit input low
// RULE_16 - area 0 width and endian taken from strap pins
// RULE_17 - endian strap sampled at reset: 0 big, 1 little
// RULE_18 - low 29 address bits decode into areas by map select
// RULE_19 - area 0 select active for every area 0 access
// RULE_20 - area 5A access uses 5A select on map 1, 5B on map 2
// RULE_21 - external wait held asserted extends the access
`timescale 1ns/1ps
module embc_ctrl
  import embc_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  // request port
  input  wire logic                          req_valid,
  output logic                               req_ready,
  input  wire logic                          req_write,
  input  wire logic [EMBC_ADDR_W-1:0]        req_addr,
  input  wire logic [3:0]                    req_lanes,
  input  wire logic [EMBC_PAGE_W-1:0]        req_beats,
  output logic                               done_pulse,
  // configuration; area fields hold one entry per area index, map select and idle counts are single
  input  wire logic                          map_select,
  input  wire logic [EMBC_AREA_NUM*2-1:0]    area_if_type,
  input  wire logic [EMBC_AREA_NUM*2-1:0]    area_width,
  input  wire logic [EMBC_AREA_NUM*EMBC_WAIT_W-1:0] area_rd_wait,
  input  wire logic [EMBC_AREA_NUM*EMBC_WAIT_W-1:0] area_wr_wait,
  input  wire logic [EMBC_IDLE_W-1:0]        idle_rw_same,
  input  wire logic [EMBC_IDLE_W-1:0]        idle_rw_diff,
  input  wire logic [EMBC_IDLE_W-1:0]        idle_rr_same,
  input  wire logic [EMBC_IDLE_W-1:0]        idle_rr_diff,
  input  wire logic [EMBC_IDLE_W-1:0]        idle_first_wr,
  // straps and external inputs
  input  wire logic                          endian_strap,
  input  wire logic                          area0_width_strap,
  input  wire logic                          ext_wait_n,
  input  wire logic                          card_io_16bit_n,
  // status
  output logic                               little_endian,
  output logic [1:0]                         area0_width,
  output logic                               card_io_16,
  output logic [1:0]                         cur_width,
  // external bus
  output logic [EMBC_ADDR_W-1:0]             ext_addr,
  output logic                               area0_select_n,
  output logic                               area4_select_n,
  output logic                               area5a_select_n,
  output logic                               area5b_select_n,
  output logic                               area6a_select_n,
  output logic                               area6b_select_n,
  output logic                               bus_cycle_start_n,
  output logic                               rw_direction,
  output logic                               read_strobe_n,
  output logic                               byte_lane3_write_n,
  output logic                               byte_lane2_write_n,
  output logic                               byte_lane1_write_n,
  output logic                               byte_lane0_write_n
);

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic wait_s, io16_s, endian_s, width_s;
  logic [3:0] pin_vec, pin_syn;
  assign pin_vec = {ext_wait_n, card_io_16bit_n, endian_strap,
                    area0_width_strap};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      embc_sync u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .rst_val (gi >= 2 ? 1'b1 : 1'b0),
        .pin_in  (pin_vec[gi] ^ (gi >= 2 ? 1'b1 : 1'b0)),
        .pin_out (pin_syn[gi])
      );
    end
  endgenerate
  // wait and 16-bit pins are active low: turn them into asserted flags
  assign {wait_s, io16_s, endian_s, width_s} =
    {~pin_syn[3], ~pin_syn[2], pin_syn[1], pin_syn[0]};

  // -------------------------------------------------------------
  // strap capture after reset release
  // -------------------------------------------------------------
  logic       endian_reg, endian_next;
  logic [1:0] a0w_reg, a0w_next;
  logic [2:0] cap_reg, cap_next;

  // capture once the filter has seen two agreeing samples
  always_comb begin
    cap_next    = cap_reg;
    endian_next = endian_reg;
    a0w_next    = a0w_reg;
    // filter output settles on the fourth edge, so sample on the fifth
    if (cap_reg != 3'h5) begin
      cap_next = cap_reg + 3'h1;
      if (cap_reg == 3'h4) begin
        endian_next = endian_s;                          // [RULE_17]
        a0w_next    = (width_s == EMBC_STRAP_W16) ?      // [RULE_16]
                      EMBC_WIDTH_16 : EMBC_WIDTH_32;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cap_reg    <= 3'h0;
      endian_reg <= EMBC_ENDIAN_RST;
      a0w_reg    <= EMBC_WIDTH_RST;
    end else if (clk_en) begin
      cap_reg    <= cap_next;
      endian_reg <= endian_next;
      a0w_reg    <= a0w_next;
    end
  end

  assign little_endian = endian_reg;
  assign area0_width   = a0w_reg;
  // big endian: input ignored, system keeps it low anyway
  assign card_io_16 = endian_reg & io16_s;               // [RULE_14] [RULE_15]

  // -------------------------------------------------------------
  // area decode
  // -------------------------------------------------------------
  logic [2:0] dec_code;
  logic       dec_half, dec_valid;
  logic [2:0] dec_idx;

  // code in bits 28:26; areas 5/6 split on bit 25 under map 1
  always_comb begin
    dec_code  = req_addr[EMBC_ADDR_W-1:EMBC_AREA_LSB];   // [RULE_18]
    // map 2 sends all of area 5/6 to the B select      [RULE_09] [RULE_20]
    dec_half  = map_select ? 1'b1 : req_addr[EMBC_HALF_BIT]; // [RULE_01]
    dec_valid = (dec_code == EMBC_AREA0_CODE) ||
                (dec_code == EMBC_AREA4_CODE) ||
                (dec_code == EMBC_AREA5_CODE) ||
                (dec_code == EMBC_AREA6_CODE);
    dec_idx   = (dec_code == EMBC_AREA5_CODE) ? {2'h1, dec_half} :
                (dec_code == EMBC_AREA6_CODE) ? {2'h2, dec_half} :
                (dec_code == EMBC_AREA4_CODE) ? 3'h1 : 3'h0;
  end

  // -------------------------------------------------------------
  // access sequencer
  // -------------------------------------------------------------
  embc_state_e st_reg, st_next;
  logic [EMBC_ADDR_W-1:0] addr_reg, addr_next;
  logic [2:0] idx_reg, idx_next;
  logic       wr_reg, wr_next, half_reg, half_next;
  logic [3:0] lanes_reg, lanes_next;
  logic [EMBC_WAIT_W-1:0] cnt_reg, cnt_next;
  logic [EMBC_PAGE_W-1:0] beat_reg, beat_next;
  logic       prev_rd_reg, prev_rd_next, any_reg, any_next;
  logic [2:0] prev_idx_reg, prev_idx_next;
  embc_if_e   cur_if;
  logic [1:0] width_w;
  logic [EMBC_WAIT_W-1:0] wait_cfg;
  logic [EMBC_IDLE_W-1:0] gap_cfg;

  always_comb begin
    cur_if   = embc_if_e'(area_if_type[idx_reg*2 +: 2]);  // [RULE_02]
    width_w  = area_width[idx_reg*2 +: 2];                // [RULE_03]
    if (idx_reg == 3'h0) begin
      width_w = a0w_reg;                                  // [RULE_16]
    end
    // card sizing follows the 16-bit input only when little endian
    if (cur_if == EMBC_IF_CARD && endian_reg) begin       // [RULE_07]
      width_w = card_io_16 ? EMBC_WIDTH_16 : EMBC_WIDTH_8;
    end
    wait_cfg = wr_reg ? area_wr_wait[idx_reg*EMBC_WAIT_W +: EMBC_WAIT_W]
                      : area_rd_wait[idx_reg*EMBC_WAIT_W +: EMBC_WAIT_W];
  end                                                     // [RULE_04]
  assign cur_width = width_w;

  // idle gap chosen from the access pair
  always_comb begin
    gap_cfg = '0;
    if (!any_reg) begin
      gap_cfg = req_write ? idle_first_wr : '0;           // [RULE_05]
    end else if (prev_rd_reg) begin
      if (req_write) begin
        gap_cfg = (prev_idx_reg == dec_idx) ? idle_rw_same : idle_rw_diff;
      end else begin
        gap_cfg = (prev_idx_reg == dec_idx) ? idle_rr_same : idle_rr_diff;
      end
    end else if (req_write) begin
      gap_cfg = idle_first_wr;
    end
  end

  assign req_ready = (st_reg == EMBC_ST_IDLE) && cap_reg == 3'h5;

  always_comb begin
    st_next       = st_reg;
    addr_next     = addr_reg;
    idx_next      = idx_reg;
    wr_next       = wr_reg;
    half_next     = half_reg;
    lanes_next    = lanes_reg;
    cnt_next      = cnt_reg;
    beat_next     = beat_reg;
    prev_rd_next  = prev_rd_reg;
    prev_idx_next = prev_idx_reg;
    any_next      = any_reg;
    unique case (st_reg)
      EMBC_ST_IDLE: begin
        if (req_valid && req_ready && dec_valid) begin
          addr_next  = req_addr;
          idx_next   = dec_idx;
          half_next  = dec_half;
          wr_next    = req_write;
          lanes_next = req_lanes;
          beat_next  = req_beats;
          cnt_next   = gap_cfg;
          st_next    = (gap_cfg == '0) ? EMBC_ST_START : EMBC_ST_GAP;
        end
      end
      EMBC_ST_GAP: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == 'h1) st_next = EMBC_ST_START;
      end
      EMBC_ST_START: begin
        cnt_next = wait_cfg;
        st_next  = EMBC_ST_WAIT;
      end
      EMBC_ST_WAIT: begin
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else begin
          st_next = EMBC_ST_HOLD;
        end
      end
      EMBC_ST_HOLD: begin
        // external wait stretches the strobe phase
        if (!wait_s) begin                                // [RULE_21]
          if (cur_if == EMBC_IF_BROM && !wr_reg && beat_reg != '0) begin
            beat_next = beat_reg - 1'b1;                  // [RULE_06]
            addr_next = addr_reg + EMBC_ADDR_W'(4);
            cnt_next  = wait_cfg;
            st_next   = EMBC_ST_WAIT;
          end else begin
            st_next = EMBC_ST_DONE;
          end
        end
      end
      EMBC_ST_DONE: begin
        prev_rd_next  = !wr_reg;
        prev_idx_next = idx_reg;
        any_next      = 1'b1;
        st_next       = EMBC_ST_IDLE;
      end
      default: st_next = EMBC_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg       <= EMBC_ST_IDLE;
      addr_reg     <= '0;
      idx_reg      <= 3'h0;
      wr_reg       <= 1'h0;
      half_reg     <= 1'h0;
      lanes_reg    <= 4'h0;
      cnt_reg      <= '0;
      beat_reg     <= '0;
      prev_rd_reg  <= 1'h0;
      prev_idx_reg <= 3'h0;
      any_reg      <= 1'h0;
    end else if (clk_en) begin
      st_reg       <= st_next;
      addr_reg     <= addr_next;
      idx_reg      <= idx_next;
      wr_reg       <= wr_next;
      half_reg     <= half_next;
      lanes_reg    <= lanes_next;
      cnt_reg      <= cnt_next;
      beat_reg     <= beat_next;
      prev_rd_reg  <= prev_rd_next;
      prev_idx_reg <= prev_idx_next;
      any_reg      <= any_next;
    end
  end

  // -------------------------------------------------------------
  // pin outputs, registered
  // -------------------------------------------------------------
  logic [5:0] cs_reg, cs_next;
  logic [3:0] we_reg, we_next;
  logic       bs_reg, bs_next, rd_reg, rd_next, dn_reg, dn_next;
  logic       act;
  logic [3:0] strb;
  embc_if_e   nxt_if;

  always_comb begin
    // outputs follow the access being entered, not the one just left
    nxt_if   = embc_if_e'(area_if_type[idx_next*2 +: 2]);
    act      = st_next inside {EMBC_ST_START, EMBC_ST_WAIT, EMBC_ST_HOLD};
    cs_next  = 6'h3F;
    if (act) begin
      unique case (idx_next)
        3'h0: cs_next[0] = 1'b0;                          // [RULE_19]
        3'h1: cs_next[1] = 1'b0;
        3'h2: cs_next[2] = 1'b0;
        3'h3: cs_next[3] = 1'b0;                          // [RULE_20]
        3'h4: cs_next[4] = 1'b0;
        3'h5: cs_next[5] = 1'b0;
        default: cs_next = 6'h3F;
      endcase
    end
    bs_next = !(st_next == EMBC_ST_START &&
                nxt_if != EMBC_IF_BYTESEL);               // [RULE_08]
    strb    = (act && st_next != EMBC_ST_START) ? lanes_next : 4'h0;
    rd_next = !(act && !wr_next && st_next != EMBC_ST_START); // [RULE_11]
    we_next = 4'hF;
    if (nxt_if == EMBC_IF_CARD) begin
      // card strobes: io write, io read, memory write
      we_next[3] = !(strb != 4'h0 && wr_next && addr_next[0]); // [RULE_13]
      we_next[2] = !(strb != 4'h0 && !wr_next && addr_next[0]);
      we_next[1] = !(strb != 4'h0 && wr_next && !addr_next[0]);
    end else if (nxt_if == EMBC_IF_BYTESEL) begin
      we_next = act ? ~lanes_next : 4'hF;                 // [RULE_12]
    end else begin
      we_next = wr_next ? ~strb : 4'hF;                   // [RULE_12]
    end
    dn_next = (st_next == EMBC_ST_DONE);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cs_reg <= 6'h3F;
      we_reg <= 4'hF;
      bs_reg <= 1'h1;
      rd_reg <= 1'h1;
      dn_reg <= 1'h0;
    end else if (clk_en) begin
      cs_reg <= cs_next;
      we_reg <= we_next;
      bs_reg <= bs_next;
      rd_reg <= rd_next;
      dn_reg <= dn_next;
    end
  end

  // card mode: selects follow the area index as in other modes, not A upper byte and B lower byte    [RULE_10]
  assign area0_select_n     = cs_reg[0];
  assign area4_select_n     = cs_reg[1];
  assign area5a_select_n    = cs_reg[2];
  assign area5b_select_n    = cs_reg[3];
  assign area6a_select_n    = cs_reg[4];
  assign area6b_select_n    = cs_reg[5];
  assign bus_cycle_start_n  = bs_reg;
  assign read_strobe_n      = rd_reg;
  assign rw_direction       = !wr_reg;
  assign byte_lane3_write_n = we_reg[3];
  assign byte_lane2_write_n = we_reg[2];
  assign byte_lane1_write_n = we_reg[1];
  assign byte_lane0_write_n = we_reg[0];
  assign ext_addr           = addr_reg;
  assign done_pulse         = dn_reg;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_map2_no_a;
    @(posedge ref_clk) disable iff (reset)
      map_select |=> ##1 (area5a_select_n && area6a_select_n);
  endproperty
  a_map2_no_a: assert property (p_map2_no_a) else $error("A select on map 2"); // [RULE_09]

  property p_one_select;
    @(posedge ref_clk) disable iff (reset)
      $countones(~cs_reg) <= 1;
  endproperty
  a_one_select: assert property (p_one_select) else $error("two selects"); // [RULE_18]

  property p_bs_pulse;
    @(posedge ref_clk) disable iff (reset)
      !bus_cycle_start_n |=> bus_cycle_start_n || !clk_en;
  endproperty
  a_bs_pulse: assert property (p_bs_pulse) else $error("start not a pulse"); // [RULE_08]

  property p_wait_hold;
    @(posedge ref_clk) disable iff (reset)
      (st_reg == EMBC_ST_HOLD && wait_s && clk_en) |=> st_reg == EMBC_ST_HOLD;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("wait ignored"); // [RULE_21]

  property p_rd_only_read;
    @(posedge ref_clk) disable iff (reset)
      !read_strobe_n |-> !wr_reg;
  endproperty
  a_rd_only_read: assert property (p_rd_only_read) else $error("read strobe on write"); // [RULE_11]

  property p_io16_big;
    @(posedge ref_clk) disable iff (reset)
      !little_endian |-> !card_io_16;
  endproperty
  a_io16_big: assert property (p_io16_big) else $error("io16 used in big endian"); // [RULE_14]

  property p_a0_width;
    @(posedge ref_clk) disable iff (reset)
      (cap_reg == 3'h5) |-> (area0_width == EMBC_WIDTH_16 ||
                             area0_width == EMBC_WIDTH_32);
  endproperty
  a_a0_width: assert property (p_a0_width) else $error("area 0 width bad"); // [RULE_16]

  sequence s_gap_start;
    st_reg == EMBC_ST_IDLE && req_valid && req_ready && dec_valid &&
    gap_cfg == '0 && clk_en;
  endsequence
  property p_no_gap;
    @(posedge ref_clk) disable iff (reset)
      s_gap_start |=> st_reg == EMBC_ST_START;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("spurious idle"); // [RULE_05]

endmodule : embc_ctrl

// *** verilog/embc_pkg.sv ***
// embc_pkg: constants, area codes and interface types for the external
// memory bus controller.
// assumes: single bus clock domain, no register bus (plain ports).
package embc_pkg;

  // -------------------------------------------------------------
  // widths and address map
  // -------------------------------------------------------------
  localparam int unsigned EMBC_ADDR_W     = 29;
  localparam int unsigned EMBC_AREA_LSB   = 26;
  localparam int unsigned EMBC_HALF_BIT   = 25;
  localparam int unsigned EMBC_WAIT_W     = 4;
  localparam int unsigned EMBC_IDLE_W     = 4;
  localparam int unsigned EMBC_PAGE_W     = 4;
  localparam int unsigned EMBC_AREA_NUM   = 8;

  // upper address field codes of the 29-bit space
  localparam logic [2:0] EMBC_AREA0_CODE  = 3'h0;
  localparam logic [2:0] EMBC_AREA4_CODE  = 3'h4;
  localparam logic [2:0] EMBC_AREA5_CODE  = 3'h5;
  localparam logic [2:0] EMBC_AREA6_CODE  = 3'h6;

  // data width field codes
  localparam logic [1:0] EMBC_WIDTH_8     = 2'h1;
  localparam logic [1:0] EMBC_WIDTH_16    = 2'h2;
  localparam logic [1:0] EMBC_WIDTH_32    = 2'h3;

  // area 0 width strap decode, endian strap decode
  localparam logic       EMBC_STRAP_W16   = 1'h0;
  localparam logic       EMBC_ENDIAN_BIG  = 1'h0;

  // reset values
  localparam logic       EMBC_MAP_RST     = 1'h0;
  localparam logic       EMBC_ENDIAN_RST  = 1'h0;
  localparam logic [1:0] EMBC_WIDTH_RST   = 2'h2;

  typedef enum logic [1:0] {
    EMBC_IF_NORMAL = 2'h0,
    EMBC_IF_BYTESEL = 2'h1,
    EMBC_IF_BROM = 2'h2,
    EMBC_IF_CARD = 2'h3
  } embc_if_e;

  typedef enum logic [2:0] {
    EMBC_ST_IDLE  = 3'h0,
    EMBC_ST_GAP   = 3'h1,
    EMBC_ST_START = 3'h2,
    EMBC_ST_WAIT  = 3'h3,
    EMBC_ST_HOLD  = 3'h4,
    EMBC_ST_DONE  = 3'h5
  } embc_state_e;

endpackage : embc_pkg

// *** verilog/embc_sync.sv ***
// embc_sync: three-stage synchroniser with agreement filter for pins.
// assumes: inputs come from outside the ref_clk domain.
`timescale 1ns/1ps
module embc_sync (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic rst_val,
  input  wire logic pin_in,
  output logic      pin_out
);
  logic s1_reg, s2_reg, s3_reg, out_reg;
  logic out_next;

  // first stage feeds only the second
  always_comb begin
    out_next = (s2_reg == s3_reg) ? s2_reg : out_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_reg  <= 1'h0;
      s2_reg  <= 1'h0;
      s3_reg  <= 1'h0;
      out_reg <= 1'h0;
    end else if (clk_en) begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  // rst_val lets an active-low pin read idle while the chain fills
  assign pin_out = out_reg ^ rst_val;
endmodule : embc_sync
